/* src/pcrb_bank.sv */
// Panel configuration register bank with strap XOR and derived controls.
// Assumes the command decoder gives one-cycle WR/RD strobes, synchronous to CLK.
// Contract
// - Resolution bit 3 picks register line count or 3-bit panel size code.
// - Lane swap bits 7:4 XOR strap give effective lane swap.
// - Register line count equals (value plus one) times eight.
// - Panel bit 0 XOR strap selects test pattern, LVDS only.
// - Panel bit 1 selects normally black or white.
// - Panel bit 4 sets source channel shift order.
// - Panel bit 5 sets gate scan direction.
// - Panel bit 6 XOR standby pin, LVDS only, switches logic off.
// - Power mode bits 5:4 XOR strap pins give effective mode.
// - Zig-zag register bits 3:0 give sixteen zig-zag settings.
// - Bits 2 and 3 set backlight-on and PWM polarity.
// - Bit 4 gates backlight on output, and PWM output only when routing bit 4 is set.
// - Dither enable with bit 6 picks H-FRC or FRC, else off.
// - Two-bit field selects one of four inversion methods.
// - Input format bit 2 selects HV or DE sync.
// - Bits 3 and 4 select LVDS depth and format, XOR straps.
// - Input format bit 7 XOR strap swaps serial lane polarity.
// - Gate mode bit 3 keeps or stops gate clock in blanking.
// - Pre-dummy bits 3:0 give dummy clock count, zero means all.
// - Routing bit 4 puts pump clock on PWM or second switch.
// - Interface bit 0 XOR strap selects serial link or LVDS.
// - Interface bit 5 XOR strap selects 3-wire or I2C.
`default_nettype none
`include "pcrb_regs.svh"
module pcrb_bank #(
    parameter int LINE_W = 12
) (
    input  wire logic              CLK,
    input  wire logic              NRST,
    input  wire logic              WR,
    input  wire logic              RD,
    input  wire logic [7:0]        ADDR,
    input  wire logic [7:0]        WDATA,
    output logic      [7:0]        RDATA,
    input  wire logic [2:0]        STRAP_RES,
    input  wire logic [3:0]        STRAP_LANE,
    input  wire logic              STRAP_TEST,
    input  wire logic              STRAP_HOLD,
    input  wire logic [1:0]        STRAP_PWR,
    input  wire logic              STRAP_DEPTH,
    input  wire logic              STRAP_FMT,
    input  wire logic              STRAP_LANE_POLARITY_SWAP,
    input  wire logic              STRAP_IF,
    input  wire logic              STRAP_CMD,
    input  wire logic              BL_ON_REQ,
    input  wire logic              BL_PWM_IN,
    input  wire logic              PUMP_CLK_IN,
    output logic                   VERTICAL_COUNT_SOURCE,
    output logic [LINE_W-1:0]      ACTIVE_LINES,
    output logic [2:0]             PANEL_SIZE_CODE,
    output logic [3:0]             LANE_ORDER_SWAP,
    output logic                   TEST_PATTERN,
    output logic                   PANEL_BLACK_WHITE_TYPE,
    output logic                   SOURCE_SHIFT_DIRECTION,
    output logic                   GATE_SCAN_DIRECTION,
    output logic                   LOW_POWER_HOLD,
    output logic [1:0]             SUPPLY_MODE_SELECT,
    output logic [3:0]             ZZ_PANEL_TYPE,
    output logic                   BACKLIGHT_ON,
    output logic                   BACKLIGHT_PULSE_OUTPUT,
    output logic                   SECOND_SWITCH_OUTPUT,
    output pcrb_pkg::pcrb_dith_t   DITHER_MODE,
    output pcrb_pkg::pcrb_inv_t    POLARITY_INVERSION_METHOD,
    output logic                   LVDS_DE_MODE,
    output logic                   LVDS_DEPTH_SELECT,
    output logic                   LVDS_FORMAT_SELECT,
    output logic                   LANE_POLARITY_SWAP,
    output logic                   BLANKING_CLOCK_KEEP,
    output logic [3:0]             PRE_DUMMY_COUNT,
    output logic                   PRE_DUMMY_ALL,
    output logic                   SERIAL_VIDEO_SEL,
    output logic                   I2C_CMD_SEL,
    output logic [7:0]             GATE_MODE,
    output logic [7:0]             VCOM_LEVEL,
    output logic [7:0]             SUPPLY_TRIM,
    output logic [7:0]             VGH_LEVEL,
    output logic [7:0]             VGL_LEVEL
);
    pcrb_pkg::pcrb_state_t st_reg;
    pcrb_pkg::pcrb_state_t st_next;
    logic                  lvds_sel;
    logic                  bl_en;
    logic [LINE_W-1:0]     reg_lines;

    always_comb begin
        st_next = st_reg;
        if (WR) begin
            unique case (ADDR)
                `PCRB_OFS_RESLANE: st_next.reslane = WDATA & `PCRB_MSK_RESLANE;
                `PCRB_OFS_VCOUNT:  st_next.vcount  = WDATA;
                `PCRB_OFS_PANEL:   st_next.panel   = WDATA & `PCRB_MSK_PANEL;
                `PCRB_OFS_ZZPWR:   st_next.zzpwr   = WDATA & `PCRB_MSK_ZZPWR;
                `PCRB_OFS_BLDITH:  st_next.bldith  = WDATA & `PCRB_MSK_BLDITH;
                `PCRB_OFS_INFMT:   st_next.infmt   = WDATA & `PCRB_MSK_INFMT;
                `PCRB_OFS_GATE:    st_next.gate    = WDATA & `PCRB_MSK_GATE;
                `PCRB_OFS_PUMP:    st_next.pump    = WDATA & `PCRB_MSK_PUMP;
                `PCRB_OFS_DUMMY:   st_next.dummy   = WDATA & `PCRB_MSK_DUMMY;
                `PCRB_OFS_OTP:     st_next.otp     = WDATA & `PCRB_MSK_OTP;
                `PCRB_OFS_IFSEL:   st_next.ifsel   = WDATA & `PCRB_MSK_IFSEL;
                `PCRB_OFS_VCOM:    st_next.vcom    = WDATA;
                `PCRB_OFS_TRIM:    st_next.trim    = WDATA & `PCRB_MSK_TRIM;
                `PCRB_OFS_VGH:     st_next.vgh     = WDATA & `PCRB_MSK_VGH;
                `PCRB_OFS_VGL:     st_next.vgl     = WDATA & `PCRB_MSK_VGL;
                default:           st_next.rdata   = st_reg.rdata;
            endcase
        end
        if (RD) begin
            // Read data is the value before any same-cycle write
            unique case (ADDR)
                `PCRB_OFS_RESLANE: st_next.rdata = st_reg.reslane;
                `PCRB_OFS_VCOUNT:  st_next.rdata = st_reg.vcount;
                `PCRB_OFS_PANEL:   st_next.rdata = st_reg.panel;
                `PCRB_OFS_ZZPWR:   st_next.rdata = st_reg.zzpwr;
                `PCRB_OFS_BLDITH:  st_next.rdata = st_reg.bldith;
                `PCRB_OFS_INFMT:   st_next.rdata = st_reg.infmt;
                `PCRB_OFS_GATE:    st_next.rdata = st_reg.gate;
                `PCRB_OFS_PUMP:    st_next.rdata = st_reg.pump;
                `PCRB_OFS_DUMMY:   st_next.rdata = st_reg.dummy;
                `PCRB_OFS_OTP:     st_next.rdata = st_reg.otp;
                `PCRB_OFS_IFSEL:   st_next.rdata = st_reg.ifsel;
                `PCRB_OFS_VCOM:    st_next.rdata = st_reg.vcom;
                `PCRB_OFS_TRIM:    st_next.rdata = st_reg.trim;
                `PCRB_OFS_VGH:     st_next.rdata = st_reg.vgh;
                `PCRB_OFS_VGL:     st_next.rdata = st_reg.vgl;
                default:           st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st_reg.reslane <= `PCRB_RST_RESLANE;
            st_reg.vcount  <= `PCRB_RST_VCOUNT;
            st_reg.panel   <= `PCRB_RST_PANEL;
            st_reg.zzpwr   <= `PCRB_RST_ZZPWR;
            st_reg.bldith  <= `PCRB_RST_BLDITH;
            st_reg.infmt   <= `PCRB_RST_INFMT;
            st_reg.gate    <= `PCRB_RST_GATE;
            st_reg.pump    <= `PCRB_RST_PUMP;
            st_reg.dummy   <= `PCRB_RST_DUMMY;
            st_reg.otp     <= `PCRB_RST_OTP;
            st_reg.ifsel   <= `PCRB_RST_IFSEL;
            st_reg.vcom    <= `PCRB_RST_VCOM;
            st_reg.trim    <= `PCRB_RST_TRIM;
            st_reg.vgh     <= `PCRB_RST_VGH;
            st_reg.vgl     <= `PCRB_RST_VGL;
            st_reg.rdata   <= 8'h00;
        end else begin
            st_reg <= st_next;
        end
    end

    assign RDATA = st_reg.rdata;

    // Strap inputs combine live, so a strap change takes effect at once
    assign SERIAL_VIDEO_SEL = st_reg.ifsel[`PCRB_B_IFSEL] ^ STRAP_IF;
    assign lvds_sel         = ~SERIAL_VIDEO_SEL;
    assign I2C_CMD_SEL      = st_reg.ifsel[`PCRB_B_CMDSEL] ^ STRAP_CMD;

    assign VERTICAL_COUNT_SOURCE = st_reg.reslane[`PCRB_B_VSRC];
    assign PANEL_SIZE_CODE = st_reg.reslane[2:0] ^ STRAP_RES;
    assign reg_lines = LINE_W'({4'h0, st_reg.vcount} + 12'h001) << 3;
    // Size code decoding lives downstream; zero here flags code mode
    assign ACTIVE_LINES = VERTICAL_COUNT_SOURCE ? reg_lines : '0;
    assign LANE_ORDER_SWAP = st_reg.reslane[7:4] ^ STRAP_LANE;

    // Test pattern and standby straps only matter on the LVDS path
    assign TEST_PATTERN = st_reg.panel[`PCRB_B_TEST] ^ (lvds_sel & STRAP_TEST);
    assign PANEL_BLACK_WHITE_TYPE = st_reg.panel[`PCRB_B_NBW];
    assign SOURCE_SHIFT_DIRECTION = st_reg.panel[`PCRB_B_SHIFT];
    assign GATE_SCAN_DIRECTION    = st_reg.panel[`PCRB_B_SCAN];
    assign LOW_POWER_HOLD = st_reg.panel[`PCRB_B_HOLD] ^ (lvds_sel & STRAP_HOLD);

    assign SUPPLY_MODE_SELECT = st_reg.zzpwr[5:4] ^ STRAP_PWR;
    assign ZZ_PANEL_TYPE      = st_reg.zzpwr[3:0];

    // Standby forces backlight outputs to their inactive level, the pulse output only when routing bit 4 is set
    assign bl_en = st_reg.bldith[`PCRB_B_BLON] & ~LOW_POWER_HOLD;
    assign BACKLIGHT_ON = st_reg.bldith[`PCRB_B_ONPOL] ^ ~(bl_en & BL_ON_REQ);
    assign BACKLIGHT_PULSE_OUTPUT = st_reg.pump[`PCRB_B_ROUTE]
        ? (st_reg.bldith[`PCRB_B_PWMPOL] ^ ~(bl_en & BL_PWM_IN))
        : PUMP_CLK_IN;
    assign SECOND_SWITCH_OUTPUT = st_reg.pump[`PCRB_B_ROUTE] & PUMP_CLK_IN;

    assign DITHER_MODE = !st_reg.bldith[`PCRB_B_DITH] ? pcrb_pkg::PCRB_DITH_OFF
        : (st_reg.bldith[`PCRB_B_HORIZONTAL_FRAME_RATE_CTRL] ? pcrb_pkg::PCRB_DITH_HORIZONTAL_FRAME_RATE_CTRL
        : pcrb_pkg::PCRB_DITH_FRC);
    assign POLARITY_INVERSION_METHOD = pcrb_pkg::pcrb_inv_t'(st_reg.infmt[1:0]);
    assign LVDS_DE_MODE       = st_reg.infmt[`PCRB_B_DEMODE];
    assign LVDS_DEPTH_SELECT  = st_reg.infmt[`PCRB_B_DEPTH] ^ STRAP_DEPTH;
    assign LVDS_FORMAT_SELECT = st_reg.infmt[`PCRB_B_FMT] ^ STRAP_FMT;
    assign LANE_POLARITY_SWAP = st_reg.infmt[`PCRB_B_LANE_POLARITY_SWAP] ^ STRAP_LANE_POLARITY_SWAP;

    assign BLANKING_CLOCK_KEEP = st_reg.gate[`PCRB_B_BLKKEEP];
    assign GATE_MODE           = st_reg.gate;
    assign PRE_DUMMY_COUNT     = st_reg.dummy[3:0];
    assign PRE_DUMMY_ALL       = (st_reg.dummy[3:0] == 4'h0);

    assign VCOM_LEVEL  = st_reg.vcom;
    assign SUPPLY_TRIM = st_reg.trim;
    assign VGH_LEVEL   = st_reg.vgh;
    assign VGL_LEVEL   = st_reg.vgl;

    // One accepted write to a given offset
    sequence s_wr(logic [7:0] ofs);
        WR && ADDR == ofs;
    endsequence

    property p_wr_store;
        @(posedge CLK) disable iff (!NRST)
        (WR && ADDR == `PCRB_OFS_VCOUNT) |=> (st_reg.vcount == $past(WDATA));
    endproperty
    a_wr_store: assert property (p_wr_store) else $error("line count write lost");

    sequence s_rd_cmd;
        RD && ADDR == `PCRB_OFS_PANEL;
    endsequence
    property p_rd_back;
        @(posedge CLK) disable iff (!NRST)
        s_rd_cmd |=> (RDATA == $past(st_reg.panel)) && ((RDATA & ~`PCRB_MSK_PANEL) == 8'h00);
    endproperty
    a_rd_back: assert property (p_rd_back) else $error("panel readback wrong");

    property p_lines;
        @(posedge CLK) disable iff (!NRST)
        VERTICAL_COUNT_SOURCE |-> ACTIVE_LINES == LINE_W'((st_reg.vcount + 12'h001) * 8);
    endproperty
    a_lines: assert property (p_lines) else $error("line count wrong");

    property p_lane;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_RESLANE) |=> (LANE_ORDER_SWAP ^ STRAP_LANE) == $past(WDATA[7:4]);
    endproperty
    a_lane: assert property (p_lane) else $error("lane swap wrong");

    property p_bl_off;
        @(posedge CLK) disable iff (!NRST)
        !st_reg.bldith[`PCRB_B_BLON] |-> BACKLIGHT_ON == ~st_reg.bldith[`PCRB_B_ONPOL];
    endproperty
    a_bl_off: assert property (p_bl_off) else $error("backlight not gated");

    property p_dith;
        @(posedge CLK) disable iff (!NRST)
        !st_reg.bldith[`PCRB_B_DITH] |-> DITHER_MODE == pcrb_pkg::PCRB_DITH_OFF;
    endproperty
    a_dith: assert property (p_dith) else $error("dither not off");

    property p_dummy;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_DUMMY) |=> PRE_DUMMY_ALL == ($past(WDATA[3:0]) == 4'h0);
    endproperty
    a_dummy: assert property (p_dummy) else $error("dummy all wrong");

    property p_if;
        @(posedge CLK) disable iff (!NRST)
        (WR && ADDR == `PCRB_OFS_IFSEL && $stable(STRAP_IF))
        |=> SERIAL_VIDEO_SEL == ($past(WDATA[0]) ^ STRAP_IF);
    endproperty
    a_if: assert property (p_if) else $error("interface select wrong");

    property p_vsrc;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_RESLANE) |=> VERTICAL_COUNT_SOURCE == $past(WDATA[3]);
    endproperty
    a_vsrc: assert property (p_vsrc) else $error("count source wrong");

    property p_code_mode;
        @(posedge CLK) disable iff (!NRST)
        !VERTICAL_COUNT_SOURCE |-> ACTIVE_LINES == '0;
    endproperty
    a_code_mode: assert property (p_code_mode) else $error("code mode lines");

    property p_size_code;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_RESLANE) |=> (PANEL_SIZE_CODE ^ STRAP_RES) == $past(WDATA[2:0]);
    endproperty
    a_size_code: assert property (p_size_code) else $error("size code wrong");

    property p_test;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_PANEL)
        |=> TEST_PATTERN == ($past(WDATA[0]) ^ (!SERIAL_VIDEO_SEL && STRAP_TEST));
    endproperty
    a_test: assert property (p_test) else $error("test pattern wrong");

    property p_nbw;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_PANEL) |=> PANEL_BLACK_WHITE_TYPE == $past(WDATA[1]);
    endproperty
    a_nbw: assert property (p_nbw) else $error("panel type wrong");

    property p_shift;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_PANEL) |=> SOURCE_SHIFT_DIRECTION == $past(WDATA[4]);
    endproperty
    a_shift: assert property (p_shift) else $error("shift order wrong");

    property p_scan;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_PANEL) |=> GATE_SCAN_DIRECTION == $past(WDATA[5]);
    endproperty
    a_scan: assert property (p_scan) else $error("scan direction wrong");

    property p_hold;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_PANEL)
        |=> LOW_POWER_HOLD == ($past(WDATA[6]) ^ (!SERIAL_VIDEO_SEL && STRAP_HOLD));
    endproperty
    a_hold: assert property (p_hold) else $error("standby wrong");

    property p_pwr;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_ZZPWR) |=> (SUPPLY_MODE_SELECT ^ STRAP_PWR) == $past(WDATA[5:4]);
    endproperty
    a_pwr: assert property (p_pwr) else $error("power mode wrong");

    property p_zz;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_ZZPWR) |=> ZZ_PANEL_TYPE == $past(WDATA[3:0]);
    endproperty
    a_zz: assert property (p_zz) else $error("zig-zag wrong");

    property p_bl_pol;
        @(posedge CLK) disable iff (!NRST)
        (st_reg.bldith[`PCRB_B_BLON] && !LOW_POWER_HOLD && BL_ON_REQ)
        |-> BACKLIGHT_ON == st_reg.bldith[`PCRB_B_ONPOL];
    endproperty
    a_bl_pol: assert property (p_bl_pol) else $error("backlight polarity");

    property p_horizontal_frame_rate_ctrl;
        @(posedge CLK) disable iff (!NRST)
        st_reg.bldith[`PCRB_B_DITH] |-> DITHER_MODE == (st_reg.bldith[`PCRB_B_HORIZONTAL_FRAME_RATE_CTRL]
            ? pcrb_pkg::PCRB_DITH_HORIZONTAL_FRAME_RATE_CTRL : pcrb_pkg::PCRB_DITH_FRC);
    endproperty
    a_horizontal_frame_rate_ctrl: assert property (p_horizontal_frame_rate_ctrl) else $error("dither mode wrong");

    property p_inv;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_INFMT) |=> POLARITY_INVERSION_METHOD == $past(WDATA[1:0]);
    endproperty
    a_inv: assert property (p_inv) else $error("inversion wrong");

    property p_de;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_INFMT) |=> LVDS_DE_MODE == $past(WDATA[2]);
    endproperty
    a_de: assert property (p_de) else $error("sync mode wrong");

    property p_depth;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_INFMT) |=> (LVDS_DEPTH_SELECT ^ STRAP_DEPTH) == $past(WDATA[3])
            && (LVDS_FORMAT_SELECT ^ STRAP_FMT) == $past(WDATA[4]);
    endproperty
    a_depth: assert property (p_depth) else $error("depth or format wrong");

    property p_lane_polarity_swap;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_INFMT) |=> (LANE_POLARITY_SWAP ^ STRAP_LANE_POLARITY_SWAP) == $past(WDATA[7]);
    endproperty
    a_lane_polarity_swap: assert property (p_lane_polarity_swap) else $error("lane polarity wrong");

    property p_blk;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_GATE) |=> BLANKING_CLOCK_KEEP == $past(WDATA[3]);
    endproperty
    a_blk: assert property (p_blk) else $error("blanking clock wrong");

    property p_route;
        @(posedge CLK) disable iff (!NRST)
        !st_reg.pump[`PCRB_B_ROUTE]
        |-> (BACKLIGHT_PULSE_OUTPUT == PUMP_CLK_IN) && !SECOND_SWITCH_OUTPUT;
    endproperty
    a_route: assert property (p_route) else $error("pump route wrong");

    property p_cmd;
        @(posedge CLK) disable iff (!NRST)
        s_wr(`PCRB_OFS_IFSEL) |=> (I2C_CMD_SEL ^ STRAP_CMD) == $past(WDATA[5]);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command port wrong");

    property p_unmapped;
        @(posedge CLK) disable iff (!NRST)
        (RD && ADDR == 8'h37) |=> RDATA == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("hole not zero");
endmodule : pcrb_bank
`default_nettype wire

/* src/pcrb_regs.svh */
// Register map of the panel configuration bank: offsets, fields and defaults.
// Assumes an 8-bit command address and 8-bit data path.
`ifndef PCRB_REGS_SVH
`define PCRB_REGS_SVH
`define PCRB_OFS_RESLANE   8'h30
`define PCRB_OFS_VCOUNT    8'h31
`define PCRB_OFS_PANEL     8'h32
`define PCRB_OFS_ZZPWR     8'h33
`define PCRB_OFS_BLDITH    8'h34
`define PCRB_OFS_INFMT     8'h35
`define PCRB_OFS_GATE      8'h36
`define PCRB_OFS_PUMP      8'h39
`define PCRB_OFS_DUMMY     8'h3A
`define PCRB_OFS_OTP       8'h3D
`define PCRB_OFS_IFSEL     8'h3F
`define PCRB_OFS_VCOM      8'h41
`define PCRB_OFS_TRIM      8'h44
`define PCRB_OFS_VGH       8'h47
`define PCRB_OFS_VGL       8'h48
`define PCRB_RST_RESLANE   8'h00
`define PCRB_RST_VCOUNT    8'h9F
`define PCRB_RST_PANEL     8'h00
`define PCRB_RST_ZZPWR     8'h21
`define PCRB_RST_BLDITH    8'hFC
`define PCRB_RST_INFMT     8'h24
`define PCRB_RST_GATE      8'h41
`define PCRB_RST_PUMP      8'h11
`define PCRB_RST_DUMMY     8'h00
`define PCRB_RST_OTP       8'h1F
`define PCRB_RST_IFSEL     8'h1A
`define PCRB_RST_VCOM      8'h5E
`define PCRB_RST_TRIM      8'hA8
`define PCRB_RST_VGH       8'h14
`define PCRB_RST_VGL       8'h66
`define PCRB_MSK_RESLANE   8'hFF
`define PCRB_MSK_PANEL     8'h73
`define PCRB_MSK_ZZPWR     8'h3F
`define PCRB_MSK_BLDITH    8'hFC
`define PCRB_MSK_INFMT     8'hBF
`define PCRB_MSK_GATE      8'hFF
`define PCRB_MSK_PUMP      8'hFF
`define PCRB_MSK_DUMMY     8'h3F
`define PCRB_MSK_OTP       8'h3F
`define PCRB_MSK_IFSEL     8'h3F
`define PCRB_MSK_TRIM      8'hFF
`define PCRB_MSK_VGH       8'hFF
`define PCRB_MSK_VGL       8'hFF
`define PCRB_B_VSRC        3
`define PCRB_B_TEST        0
`define PCRB_B_NBW         1
`define PCRB_B_SHIFT       4
`define PCRB_B_SCAN        5
`define PCRB_B_HOLD        6
`define PCRB_B_ONPOL       2
`define PCRB_B_PWMPOL      3
`define PCRB_B_BLON        4
`define PCRB_B_DITH        5
`define PCRB_B_HORIZONTAL_FRAME_RATE_CTRL        6
`define PCRB_B_DEMODE      2
`define PCRB_B_DEPTH       3
`define PCRB_B_FMT         4
`define PCRB_B_LANE_POLARITY_SWAP        7
`define PCRB_B_BLKKEEP     3
`define PCRB_B_ROUTE       4
`define PCRB_B_IFSEL       0
`define PCRB_B_CMDSEL      5
`endif

/* src/pcrb_pkg.sv */
// Types shared by the panel configuration bank.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package pcrb_pkg;
    typedef enum logic [1:0] {
        PCRB_INV_1LINE = 2'h0,
        PCRB_INV_2LINE = 2'h1,
        PCRB_INV_4LINE = 2'h2,
        PCRB_INV_COL   = 2'h3
    } pcrb_inv_t;

    typedef enum logic [1:0] {
        PCRB_DITH_OFF  = 2'h0,
        PCRB_DITH_FRC  = 2'h1,
        PCRB_DITH_HORIZONTAL_FRAME_RATE_CTRL = 2'h2
    } pcrb_dith_t;

    typedef struct packed {
        logic [7:0] reslane;
        logic [7:0] vcount;
        logic [7:0] panel;
        logic [7:0] zzpwr;
        logic [7:0] bldith;
        logic [7:0] infmt;
        logic [7:0] gate;
        logic [7:0] pump;
        logic [7:0] dummy;
        logic [7:0] otp;
        logic [7:0] ifsel;
        logic [7:0] vcom;
        logic [7:0] trim;
        logic [7:0] vgh;
        logic [7:0] vgl;
        logic [7:0] rdata;
    } pcrb_state_t;
endpackage : pcrb_pkg
`default_nettype wire

/* testbench/pcrb_bank_tb_top.sv */
// Self-checking bench for the panel configuration register bank.
// Assumes pcrb_pkg and pcrb_bank are compiled ahead of this file.
`default_nettype none
module pcrb_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] OFS [0:14] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36,
        8'h39, 8'h3A, 8'h3D, 8'h3F, 8'h41, 8'h44, 8'h47, 8'h48};
    localparam logic [7:0] DEF [0:14] = '{8'h00, 8'h9F, 8'h00, 8'h21, 8'hFC, 8'h24, 8'h41,
        8'h11, 8'h00, 8'h1F, 8'h1A, 8'h5E, 8'hA8, 8'h14, 8'h66};
    localparam logic [7:0] MSK [0:14] = '{8'hFF, 8'hFF, 8'h73, 8'h3F, 8'hFC, 8'hBF, 8'hFF,
        8'hFF, 8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic        clk   = 1'b0;
    logic        nrst  = 1'b0;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [7:0]  addr  = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic [18:0] pin   = 19'h00000;
    logic [31:0] st    = 32'h917C68F5;
    logic [7:0]  m [0:15];
    int          fails = 0;
    int          n_compared = 0;
    logic [7:0]  rdata;
    logic        vsrc, tpat, panel_black_white_type, shdir, scdir, hold, bl_on, bl_pul, sec_sw;
    logic        de, dep, fmt, lane_polarity_swap, blk, pd_all, svid, i2c;
    logic [11:0] lines;
    logic [2:0]  psz;
    logic [3:0]  lsw, zz, pdc;
    logic [1:0]  smode;
    logic [7:0]  gmode, vcom, trim, vgh, vgl;
    pcrb_pkg::pcrb_dith_t dith;
    pcrb_pkg::pcrb_inv_t  inv;

    pcrb_bank #(.LINE_W(12)) i_dut (
        .CLK(clk), .NRST(nrst), .WR(wr), .RD(rd), .ADDR(addr), .WDATA(wdata), .RDATA(rdata),
        .STRAP_RES(pin[2:0]), .STRAP_LANE(pin[6:3]), .STRAP_TEST(pin[7]), .STRAP_HOLD(pin[8]),
        .STRAP_PWR(pin[10:9]), .STRAP_DEPTH(pin[11]), .STRAP_FMT(pin[12]),
        .STRAP_LANE_POLARITY_SWAP(pin[13]), .STRAP_IF(pin[14]), .STRAP_CMD(pin[15]), .BL_ON_REQ(pin[16]),
        .BL_PWM_IN(pin[17]), .PUMP_CLK_IN(pin[18]), .VERTICAL_COUNT_SOURCE(vsrc),
        .ACTIVE_LINES(lines), .PANEL_SIZE_CODE(psz), .LANE_ORDER_SWAP(lsw),
        .TEST_PATTERN(tpat), .PANEL_BLACK_WHITE_TYPE(panel_black_white_type), .SOURCE_SHIFT_DIRECTION(shdir),
        .GATE_SCAN_DIRECTION(scdir), .LOW_POWER_HOLD(hold), .SUPPLY_MODE_SELECT(smode),
        .ZZ_PANEL_TYPE(zz), .BACKLIGHT_ON(bl_on), .BACKLIGHT_PULSE_OUTPUT(bl_pul),
        .SECOND_SWITCH_OUTPUT(sec_sw), .DITHER_MODE(dith), .POLARITY_INVERSION_METHOD(inv),
        .LVDS_DE_MODE(de), .LVDS_DEPTH_SELECT(dep), .LVDS_FORMAT_SELECT(fmt),
        .LANE_POLARITY_SWAP(lane_polarity_swap), .BLANKING_CLOCK_KEEP(blk), .PRE_DUMMY_COUNT(pdc),
        .PRE_DUMMY_ALL(pd_all), .SERIAL_VIDEO_SEL(svid), .I2C_CMD_SEL(i2c), .GATE_MODE(gmode),
        .VCOM_LEVEL(vcom), .SUPPLY_TRIM(trim), .VGH_LEVEL(vgh), .VGL_LEVEL(vgl)
    );

    always #50 clk = ~clk;

    function automatic logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction : rnd

    function automatic int idx(input logic [7:0] a);
        for (int i = 0; i < 15; i++) begin
            if (OFS[i] == a) return i;
        end
        return 15;
    endfunction : idx

    task automatic finish_test;
        if (fails == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    // Straps and levels move every cycle so every XOR path is exercised
    task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        wr = w;
        rd = r;
        addr = a;
        wdata = d;
        pin = 19'(rnd() >> 13);
    endtask : op

    task automatic check_all;
        logic lv;
        logic hd;
        logic en;
        #1;
        lv = ~(m[10][0] ^ pin[14]);
        hd = m[2][6] ^ (lv & pin[8]);
        en = m[4][4] & ~hd;
        chk("vsrc", vsrc, m[0][3]);
        chk("lines", lines, m[0][3] ? (32'(m[1]) + 1) * 8 : 0);
        chk("psz", psz, m[0][2:0] ^ pin[2:0]);
        chk("lsw", lsw, m[0][7:4] ^ pin[6:3]);
        chk("tpat", tpat, m[2][0] ^ (lv & pin[7]));
        chk("nbw", panel_black_white_type, m[2][1]);
        chk("shdir", shdir, m[2][4]);
        chk("scdir", scdir, m[2][5]);
        chk("hold", hold, hd);
        chk("smode", smode, m[3][5:4] ^ pin[10:9]);
        chk("zz", zz, m[3][3:0]);
        chk("bl_on", bl_on, m[4][2] ^ !(en & pin[16]));
        chk("bl_pul", bl_pul, m[7][4] ? m[4][3] ^ !(en & pin[17]) : pin[18]);
        chk("sec_sw", sec_sw, m[7][4] & pin[18]);
        chk("dith", dith, m[4][5] ? (m[4][6] ? 2 : 1) : 0);
        chk("inv", inv, m[5][1:0]);
        chk("de", de, m[5][2]);
        chk("dep", dep, m[5][3] ^ pin[11]);
        chk("fmt", fmt, m[5][4] ^ pin[12]);
        chk("lane_polarity_swap", lane_polarity_swap, m[5][7] ^ pin[13]);
        chk("blk", blk, m[6][3]);
        chk("gmode", gmode, m[6]);
        chk("pdc", {pd_all, pdc}, {m[8][3:0] == 4'h0, m[8][3:0]});
        chk("svid", svid, m[10][0] ^ pin[14]);
        chk("i2c", i2c, m[10][5] ^ pin[15]);
        chk("levels", {vcom, trim, vgh, vgl}, {m[11], m[12], m[13], m[14]});
    endtask : check_all

    // Write, read back on the very next edge, then check every output
    task automatic wrd(input logic [7:0] a, input logic [7:0] d);
        int i;
        i = idx(a);
        op(1'b1, 1'b0, a, d);
        op(1'b0, 1'b1, a, 8'h00);
        if (i < 15) m[i] = d & MSK[i];
        op(1'b0, 1'b0, a, 8'h00);
        check_all();
        chk("rdata", rdata, m[i]);
    endtask : wrd

    task automatic rd_only(input logic [7:0] a);
        op(1'b0, 1'b1, a, 8'h00);
        op(1'b0, 1'b0, a, 8'h00);
        #1 chk("rdata", rdata, m[idx(a)]);
    endtask : rd_only

    task automatic do_reset;
        for (int i = 0; i < 15; i++) m[i] = DEF[i];
        m[15] = 8'h00;
        @(negedge clk);
        nrst = 1'b0;
        #1 chk("rdata_rst", rdata, 8'h00);
        repeat (2) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 16; i++) rd_only(i < 15 ? OFS[i] : 8'h37);
        check_all();
    endtask : do_reset

    initial begin
        logic [31:0] r;
        do_reset();
        for (int i = 0; i < 15; i++) begin
            wrd(OFS[i], 8'hFF);
            wrd(OFS[i], 8'h00);
        end
        wrd(8'h37, 8'hFF);
        wrd(8'h30, 8'h08);
        wrd(8'h31, 8'h00);
        wrd(8'h31, 8'hFF);
        for (int i = 0; i < 4; i++) begin
            wrd(8'h35, 8'(i));
            wrd(8'h34, 8'(i << 5) | 8'h14);
        end
        // A read in the write cycle must see the old contents
        op(1'b1, 1'b1, 8'h41, 8'h3C);
        op(1'b0, 1'b0, 8'h41, 8'h00);
        #1 chk("rdata_old", rdata, m[11]);
        m[11] = 8'h3C;
        rd_only(8'h41);
        repeat (300) begin
            r = rnd();
            wrd(r[3:0] < 4'hF ? OFS[r[3:0]] : 8'h3B, r[15:8]);
        end
        do_reset();
        finish_test();
    end

    initial begin
        #2000000;
        fails++;
        finish_test();
    end
endmodule : pcrb_bank_tb_top
`default_nettype wire
